/* core/adc_port_cfg.svh */
// Purpose: Shared constants for the converter serial register port, both ends
// Assumes: 100 MHz system clock on both ends; host makes the serial clock
// Notes: Register codes sit in command bits 6:4, read flag in bit 3
// Behaviour
// R1 - Six registers; every access starts with command
// R2 - Ready shown on pin and command bit
// R3 - Registers 8 bits; result 16; calibration 24
// R4 - Access follows command bits immediately, no gap
// R5 - Output line silent during write accesses
// R6 - Input line ignored during read accesses
// R7 - Most significant bit first both directions
// R8 - Host clock idles high, polarity/phase one
// R9 - Framed host: clock at most 3 MHz
// R10 - Host configures all registers after reset; the host boot writes only the clock and setup registers
// R11 - Host reads result only after ready flagged
// R12 - Command picks read/write and target register
// R13 - Ready low on new result, high after read
// R14 - Thirty-two ones resynchronise, registers kept; the first eight ones still load the stored command bits with 7F
`ifndef ADC_PORT_CFG_SVH
`define ADC_PORT_CFG_SVH

`define REG_COMM        3'h0
`define REG_SETUP       3'h1
`define REG_CLOCK       3'h2
`define REG_DATA        3'h3
`define REG_OFFSET      3'h6
`define REG_GAIN        3'h7

`define CMD_READY_BIT   7
`define CMD_RS_HI       6
`define CMD_RS_LO       4
`define CMD_RW_BIT      3

`define LEN_NARROW      5'h08
`define LEN_RESULT      5'h10
`define LEN_CAL         5'h18
`define RESYNC_ONES     6'h20

`define COMM_RST        7'h00
`define SETUP_RST       8'h00
`define CLOCK_RST       8'h00
`define OFFSET_RST      24'h00_0000
`define GAIN_RST        24'h00_0000
`define RESULT_RST      16'h0000

`define BOOT_CLOCK      8'h18
`define BOOT_SETUP      8'h40

`define CLK_PERIOD_NS   10
`define SCLK_HALF_NS    200
`define SCLK_HALF_CYC   ((`SCLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* core/adc_port_pkg.sv */
// Purpose: Types and shared decoding for the converter serial register port
// Assumes: adc_port_cfg.svh supplies the numeric constants
// Notes: Register width decoding is shared by both ends
`include "adc_port_cfg.svh"

package adc_port_pkg;

  typedef logic [2:0] reg_code_t;

  typedef enum logic [1:0] {
    st_cmd,
    st_write,
    st_read
  } dev_state_e;

  typedef enum logic [2:0] {
    hs_boot,
    hs_idle,
    hs_wait_ready,
    hs_run,
    hs_gap
  } host_state_e;

  // Width in bits of the register behind a code
  function automatic logic [4:0] reg_bits(input reg_code_t code);
    if (code == `REG_DATA) begin
      return `LEN_RESULT;
    end else if (code == `REG_OFFSET || code == `REG_GAIN) begin
      return `LEN_CAL;
    end else begin
      return `LEN_NARROW;
    end
  endfunction : reg_bits

endpackage : adc_port_pkg

/* core/adc_port_if.sv */
// Purpose: Serial link between the converter port and its host
// Assumes: Device data output has a pull-up when not driven
// Notes: Chip select is low while either host frame output is low
`timescale 1ns/1ps

interface adc_port_if;
  logic sclk;                  // Serial clock from host
  logic host_transmit_frame_n; // Host transmit frame, active low
  logic host_receive_frame_n;  // Host receive frame, active low
  logic mosi;                  // Host to device data
  logic dout;                  // Device data output
  logic dout_oe;               // Device drives dout when high
  logic result_ready_n;        // New result flagged, active low
  wire  cs_n;                  // Device select, active low
  wire  miso;                  // Resolved device data line

  assign cs_n = host_transmit_frame_n & host_receive_frame_n;
  assign miso = dout_oe ? dout : 1'b1;

  modport dev (input sclk, input cs_n, input mosi,
               output dout, output dout_oe, output result_ready_n);
  modport host (output sclk, output host_transmit_frame_n, output host_receive_frame_n,
                output mosi, input miso, input result_ready_n);
endinterface : adc_port_if

/* core/adc_port_device.sv */
// Purpose: Converter end of the serial register port
// Assumes: Host clock idles high, data changes on falling and is taken on rising edge
// Notes: Chip select gates edges and the output enable but resets no state, so a wide register may span several frames
`timescale 1ns/1ps
`include "adc_port_cfg.svh"

module adc_port_device (
  input  wire logic        clk,            // System clock
  input  wire logic        reset,          // Asynchronous reset, active high
  adc_port_if.dev          link,           // Serial link
  input  wire logic [15:0] result_word,    // New conversion result
  input  wire logic        result_strobe,  // One-cycle pulse loading result_word
  output logic [7:0]       setup_value,    // Setup register contents
  output logic [7:0]       clock_value,    // Clock register contents
  output logic [23:0]      offset_value,   // Offset calibration contents
  output logic [23:0]      gain_value      // Gain calibration contents
);

  // Bit order in the sampled vectors: {cs_n, sclk, mosi}
  logic [2:0]                sync1;
  logic [2:0]                sync2;
  logic [2:0]                sync3;
  logic [2:0]                filt;
  logic [2:0]                filt_d;
  adc_port_pkg::dev_state_e  state;
  adc_port_pkg::reg_code_t   target;
  logic [4:0]                target_len;
  logic [4:0]                bit_cnt;
  logic [23:0]               shreg;
  logic [5:0]                ones_cnt;
  logic [6:0]                comm;
  logic [15:0]               result;
  logic                      rise_ok;
  logic                      fall_ok;
  logic                      resync;
  logic                      last_bit;
  logic                      cmd_done;
  logic                      wr_done;
  logic                      rd_done;
  logic [23:0]               next_word;
  logic [7:0]                next_cmd;
  adc_port_pkg::reg_code_t   next_target;

  // Pins reach the clock domain through three flops; the filtered level moves
  // only when the second and third agree, so a glitch of one cycle is dropped
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1  <= 3'h7;
      sync2  <= 3'h7;
      sync3  <= 3'h7;
      filt   <= 3'h7;
      filt_d <= 3'h7;
    end else begin
      sync1  <= {link.cs_n, link.sclk, link.mosi};
      sync2  <= sync1;
      sync3  <= sync2;
      filt   <= (sync2 & sync3) | (filt & (sync2 ^ sync3));
      filt_d <= filt;
    end
  end

  always_comb begin
    rise_ok     = filt[1] & ~filt_d[1] & ~filt[2];
    fall_ok     = ~filt[1] & filt_d[1] & ~filt[2];
    next_word   = {shreg[22:0], filt[0]};
    next_cmd    = next_word[7:0];
    next_target = next_cmd[`CMD_RS_HI:`CMD_RS_LO];
    resync      = rise_ok & filt[0] & (ones_cnt == `RESYNC_ONES - 6'h01);   // see R14
    last_bit    = bit_cnt == target_len - 5'h01;
    cmd_done    = rise_ok & ~resync & (state == adc_port_pkg::st_cmd) & (bit_cnt == 5'h07);
    wr_done     = rise_ok & ~resync & (state == adc_port_pkg::st_write) & last_bit;
    rd_done     = rise_ok & ~resync & (state == adc_port_pkg::st_read) & last_bit;
  end

  // Counts run of ones on the input whatever the state, reads included
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ones_cnt <= 6'h00;
    end else if (rise_ok) begin
      if (!filt[0] || resync) begin
        ones_cnt <= 6'h00;
      end else begin
        ones_cnt <= ones_cnt + 6'h01;   // see R14
      end
    end
  end

  // Sequencer: command byte, then the access it selects
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state      <= adc_port_pkg::st_cmd;
      bit_cnt    <= 5'h00;
      shreg      <= 24'h00_0000;
      target     <= `REG_COMM;
      target_len <= `LEN_NARROW;
    end else if (resync) begin
      state   <= adc_port_pkg::st_cmd;   // see R14
      bit_cnt <= 5'h00;
    end else if (rise_ok) begin
      case (state)
        adc_port_pkg::st_cmd: begin
          shreg <= next_word;   // see R7
          if (bit_cnt == 5'h07) begin
            bit_cnt    <= 5'h00;
            target     <= next_target;   // see R12
            target_len <= adc_port_pkg::reg_bits(next_target);   // see R3
            if (next_cmd[`CMD_RW_BIT]) begin
              state <= adc_port_pkg::st_read;   // see R4
              shreg <= read_value(next_target);
            end else if (next_target == `REG_COMM) begin
              state <= adc_port_pkg::st_cmd;   // see R1
            end else begin
              state <= adc_port_pkg::st_write;   // see R4
            end
          end else begin
            bit_cnt <= bit_cnt + 5'h01;
          end
        end
        adc_port_pkg::st_write: begin
          shreg <= next_word;   // see R7
          if (last_bit) begin
            state   <= adc_port_pkg::st_cmd;   // see R1
            bit_cnt <= 5'h00;
          end else begin
            bit_cnt <= bit_cnt + 5'h01;
          end
        end
        adc_port_pkg::st_read: begin
          // Input bits are not looked at here
          if (last_bit) begin   // see R6
            state   <= adc_port_pkg::st_cmd;
            bit_cnt <= 5'h00;
          end else begin
            bit_cnt <= bit_cnt + 5'h01;
          end
        end
        default: begin
          state <= adc_port_pkg::st_cmd;
        end
      endcase
    end else if (fall_ok && state == adc_port_pkg::st_read) begin
      shreg <= {shreg[22:0], 1'b0};   // see R7
    end
  end

  // Register contents, left aligned so the first bit out is the top bit
  function automatic logic [23:0] read_value(input adc_port_pkg::reg_code_t code);
    if (code == `REG_COMM) begin
      return {link.result_ready_n, comm, 16'h0000};   // see R2
    end else if (code == `REG_SETUP) begin
      return {setup_value, 16'h0000};
    end else if (code == `REG_CLOCK) begin
      return {clock_value, 16'h0000};
    end else if (code == `REG_DATA) begin
      return {result, 8'h00};
    end else if (code == `REG_OFFSET) begin
      return offset_value;
    end else if (code == `REG_GAIN) begin
      return gain_value;
    end else begin
      return 24'h00_0000;
    end
  endfunction : read_value

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      comm <= `COMM_RST;
    end else if (cmd_done) begin
      comm <= next_cmd[6:0];   // see R12
    end
  end

  // Wide registers are committed only once all their bits have arrived
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      setup_value  <= `SETUP_RST;
      clock_value  <= `CLOCK_RST;
      offset_value <= `OFFSET_RST;
      gain_value   <= `GAIN_RST;
    end else if (wr_done) begin
      if (target == `REG_SETUP) begin
        setup_value <= next_word[7:0];
      end else if (target == `REG_CLOCK) begin
        clock_value <= next_word[7:0];
      end else if (target == `REG_OFFSET) begin
        offset_value <= next_word;   // see R3
      end else if (target == `REG_GAIN) begin
        gain_value <= next_word;   // see R3
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      result <= `RESULT_RST;
    end else if (result_strobe) begin
      result <= result_word;
    end
  end

  // A new result wins over a read finishing in the same cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      link.result_ready_n <= 1'b1;
    end else if (result_strobe) begin
      link.result_ready_n <= 1'b0;   // see R13
    end else if (rd_done && target == `REG_DATA) begin
      link.result_ready_n <= 1'b1;   // see R13
    end
  end

  // Output is driven only while a read is under way and the port is selected
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      link.dout    <= 1'b0;
      link.dout_oe <= 1'b0;
    end else begin
      link.dout_oe <= (state == adc_port_pkg::st_read) & ~filt[2];   // see R5
      if (state != adc_port_pkg::st_read) begin
        link.dout <= 1'b0;   // see R5
      end else if (fall_ok) begin
        link.dout <= shreg[23];   // see R7
      end
    end
  end

endmodule : adc_port_device

/* core/adc_port_host.sv */
// Purpose: Host end of the serial register port, framed master
// Assumes: Device needs command byte before every access
// Notes: Clock idles high; a data read waits for the ready flag
`timescale 1ns/1ps
`include "adc_port_cfg.svh"

module adc_port_host (
  input  wire logic        clk,          // System clock
  input  wire logic        reset,        // Asynchronous reset, active high
  adc_port_if.host         link,         // Serial link
  input  wire logic        req_valid,    // Request present
  output logic             req_ready,    // Host can take a request
  input  wire logic        req_read,     // 1 read, 0 write
  input  wire logic [2:0]  req_reg,      // Target register code
  input  wire logic [23:0] req_wdata,    // Write data, right aligned
  input  wire logic        req_resync,   // Send thirty-two ones instead
  output logic             rsp_valid,    // One-cycle pulse with read data
  output logic [23:0]      rsp_data,     // Read data, right aligned
  output logic             boot_done     // Start-up configuration written
);

  localparam int HALF = `SCLK_HALF_CYC;

  logic [1:0]                sync1;
  logic [1:0]                sync2;
  logic [1:0]                sync3;
  logic [1:0]                filt;
  adc_port_pkg::host_state_e state;
  logic                      boot_idx;
  logic [7:0]                half_cnt;
  logic [5:0]                bit_cnt;
  logic [5:0]                total;
  logic [31:0]               tx;
  logic [23:0]               rx;
  logic                      cur_read;
  logic                      take;
  logic                      half_end;
  logic [4:0]                next_len;
  logic [7:0]                next_cmd;
  logic [31:0]               next_tx;
  logic                      in_data;

  // Bit order {result_ready_n, miso}
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1 <= 2'h3;
      sync2 <= 2'h3;
      sync3 <= 2'h3;
      filt  <= 2'h3;
    end else begin
      sync1 <= {link.result_ready_n, link.miso};
      sync2 <= sync1;
      sync3 <= sync2;
      filt  <= (sync2 & sync3) | (filt & (sync2 ^ sync3));
    end
  end

  always_comb begin
    take     = req_valid & req_ready;
    half_end = half_cnt == 8'(HALF - 1);
    next_len = adc_port_pkg::reg_bits(req_reg);
    next_cmd = {1'b0, req_reg, req_read, 3'h0};   // see R12
    next_tx  = {next_cmd, req_read ? 24'h00_0000 : (req_wdata << (5'd24 - next_len))};
    in_data  = bit_cnt >= 6'h08;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      half_cnt <= 8'h00;
    end else if (state == adc_port_pkg::hs_run || state == adc_port_pkg::hs_gap) begin
      half_cnt <= half_end ? 8'h00 : half_cnt + 8'h01;   // see R9
    end else begin
      half_cnt <= 8'h00;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state                      <= adc_port_pkg::hs_boot;
      boot_idx                   <= 1'b0;
      boot_done                  <= 1'b0;
      req_ready                  <= 1'b0;
      bit_cnt                    <= 6'h00;
      total                      <= 6'h00;
      tx                         <= 32'h0000_0000;
      rx                         <= 24'h00_0000;
      cur_read                   <= 1'b0;
      rsp_valid                  <= 1'b0;
      rsp_data                   <= 24'h00_0000;
      link.sclk                  <= 1'b1;
      link.mosi                  <= 1'b1;
      link.host_transmit_frame_n <= 1'b1;
      link.host_receive_frame_n  <= 1'b1;
    end else begin
      rsp_valid <= 1'b0;
      case (state)
        adc_port_pkg::hs_boot: begin
          // Writes clock then setup register, each behind its command byte
          tx       <= boot_idx ? {1'b0, `REG_SETUP, 4'h0, `BOOT_SETUP, 16'h0000}
                               : {1'b0, `REG_CLOCK, 4'h0, `BOOT_CLOCK, 16'h0000};   // see R10
          total    <= 6'h10;
          cur_read <= 1'b0;
          bit_cnt  <= 6'h00;
          state    <= adc_port_pkg::hs_run;
        end
        adc_port_pkg::hs_idle: begin
          req_ready <= 1'b1;
          if (take) begin
            req_ready <= 1'b0;
            bit_cnt   <= 6'h00;
            tx        <= req_resync ? 32'hFFFF_FFFF : next_tx;   // see R14
            total     <= req_resync ? `RESYNC_ONES : 6'h08 + {1'b0, next_len};   // see R1
            cur_read  <= req_read & ~req_resync;
            rx        <= 24'h00_0000;
            if (req_read && !req_resync && req_reg == `REG_DATA) begin
              state <= adc_port_pkg::hs_wait_ready;
            end else begin
              state <= adc_port_pkg::hs_run;
            end
          end
        end
        adc_port_pkg::hs_wait_ready: begin
          if (!filt[1]) begin
            state <= adc_port_pkg::hs_run;   // see R11
          end
        end
        adc_port_pkg::hs_run: begin
          if (half_end && link.sclk) begin
            // Falling edge: present next bit and pick the frame it belongs to
            link.sclk                  <= 1'b0;   // see R8
            link.mosi                  <= tx[31];   // see R7
            tx                         <= {tx[30:0], 1'b0};
            link.host_transmit_frame_n <= cur_read & in_data;   // see R9
            link.host_receive_frame_n  <= ~(cur_read & in_data);   // see R9
          end else if (half_end) begin
            link.sclk <= 1'b1;
            bit_cnt   <= bit_cnt + 6'h01;
            if (cur_read && in_data) begin
              rx <= {rx[22:0], filt[0]};   // see R7
            end
            if (bit_cnt == total - 6'h01) begin
              state <= adc_port_pkg::hs_gap;
            end
          end
        end
        adc_port_pkg::hs_gap: begin
          // Quiet half period lets the device ready flag settle before the next read
          link.host_transmit_frame_n <= 1'b1;
          link.host_receive_frame_n  <= 1'b1;
          link.mosi                  <= 1'b1;
          if (half_end) begin
            if (cur_read) begin
              rsp_valid <= 1'b1;
              // Cleared at take, so bits above the register width read as zero
              rsp_data  <= rx;   // see R3
            end
            if (!boot_done && !boot_idx) begin
              boot_idx <= 1'b1;
              state    <= adc_port_pkg::hs_boot;
            end else begin
              boot_done <= 1'b1;
              state     <= adc_port_pkg::hs_idle;
            end
          end
        end
        default: begin
          state <= adc_port_pkg::hs_idle;
        end
      endcase
    end
  end

endmodule : adc_port_host

/* bench/adc_port_sva.sv */
// Purpose: Checker for the serial link between host and converter ends
// Assumes: Host half period of 20 system clocks, command low bits zero
// Notes: Sees only the interface signals
`timescale 1ns/1ps

module adc_port_sva (
  input wire logic clk,                   // System clock
  input wire logic reset,                 // Asynchronous reset, active high
  input wire logic sclk,                  // Serial clock
  input wire logic host_transmit_frame_n, // Transmit frame, active low
  input wire logic host_receive_frame_n,  // Receive frame, active low
  input wire logic cs_n,                  // Device select, active low
  input wire logic mosi,                  // Host to device data
  input wire logic miso,                  // Resolved device data
  input wire logic dout_oe,               // Device drive enable
  input wire logic result_ready_n         // Result flag, active low
);
  logic       sclk_q;
  logic       cs_n_q;
  logic [7:0] low_cnt;
  logic [5:0] bit_cnt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclk_q <= 1'b1;
      cs_n_q <= 1'b1;
    end else begin
      sclk_q <= sclk;
      cs_n_q <= cs_n;
    end
  end

  // Saturates so a long clock-low phase never wraps into a short count
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      low_cnt <= 8'h00;
    end else if (sclk) begin
      low_cnt <= 8'h00;
    end else if (low_cnt != 8'hFF) begin
      low_cnt <= low_cnt + 8'h01;
    end
  end

  // Kept through the cycle cs_n rises so a rise in that cycle still counts
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bit_cnt <= 6'h00;
    end else if (cs_n && cs_n_q) begin
      bit_cnt <= 6'h00;
    end else if (sclk && !sclk_q) begin
      bit_cnt <= bit_cnt + 6'h01;
    end
  end

  property p_clock_idle; cs_n |-> sclk; endproperty
  a_clock_idle: assert property (p_clock_idle)
    else $error("serial clock low outside a frame");

  property p_half_period; $rose(sclk) |-> low_cnt >= 8'h11; endproperty
  a_half_period: assert property (p_half_period)
    else $error("serial clock low phase too short");

  property p_mosi_steady; (!cs_n && sclk && sclk_q) |-> $stable(mosi); endproperty
  a_mosi_steady: assert property (p_mosi_steady)
    else $error("host data moved while clock high");

  property p_miso_steady;
    (!host_receive_frame_n && sclk && sclk_q) |-> $stable(miso);
  endproperty
  a_miso_steady: assert property (p_miso_steady)
    else $error("device data moved while clock high");

  property p_oe_only_read; ($rose(dout_oe) && !mosi) |-> ##[1:30] !host_receive_frame_n; endproperty
  a_oe_only_read: assert property (p_oe_only_read)
    else $error("device drove output outside a read");

  property p_oe_quiet; (cs_n && $past(cs_n, 8)) |-> !dout_oe; endproperty
  a_oe_quiet: assert property (p_oe_quiet)
    else $error("device drove output while deselected");

  property p_frame_bits;
    $rose(cs_n) |-> ##1 (bit_cnt == 6'h10 || bit_cnt == 6'h18 || bit_cnt == 6'h20);
  endproperty
  a_frame_bits: assert property (p_frame_bits)
    else $error("frame length not command plus register");

  property p_ready_release; $rose(result_ready_n) |-> !$past(host_receive_frame_n, 8); endproperty
  a_ready_release: assert property (p_ready_release)
    else $error("ready flag cleared without a read");

endmodule : adc_port_sva

/* bench/tb.sv */
// Purpose: Self-checking bench joining host and converter ends
// Assumes: Host boot writes clock then setup before taking requests
// Notes: Stimulus changes on falling clock edges
`timescale 1ns/1ps
`include "adc_port_cfg.svh"

module tb;
  logic        clk;
  logic        reset;
  logic [15:0] result_word;
  logic        result_strobe;
  logic [7:0]  setup_value;
  logic [7:0]  clock_value;
  logic [23:0] offset_value;
  logic [23:0] gain_value;
  logic        req_valid;
  logic        req_ready;
  logic        req_read;
  logic [2:0]  req_reg;
  logic [23:0] req_wdata;
  logic        req_resync;
  logic        rsp_valid;
  logic [23:0] rsp_data;
  logic        boot_done;
  logic [23:0] rd;
  logic [2:0]  codes [4];
  logic [23:0] vals [4];
  int          mismatches;
  int          checked;

  adc_port_if bus ();

  adc_port_device adc_port_device_inst (.clk(clk), .reset(reset), .link(bus),
    .result_word(result_word), .result_strobe(result_strobe), .setup_value(setup_value),
    .clock_value(clock_value), .offset_value(offset_value), .gain_value(gain_value));

  adc_port_host adc_port_host_inst (.clk(clk), .reset(reset), .link(bus),
    .req_valid(req_valid), .req_ready(req_ready), .req_read(req_read), .req_reg(req_reg),
    .req_wdata(req_wdata), .req_resync(req_resync), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .boot_done(boot_done));

  adc_port_sva adc_port_sva_inst (.clk(clk), .reset(reset), .sclk(bus.sclk),
    .host_transmit_frame_n(bus.host_transmit_frame_n),
    .host_receive_frame_n(bus.host_receive_frame_n), .cs_n(bus.cs_n), .mosi(bus.mosi),
    .miso(bus.miso), .dout_oe(bus.dout_oe), .result_ready_n(bus.result_ready_n));

  always #5 clk = ~clk;

  task automatic check(input logic [23:0] seen, input logic [23:0] want);
    checked++;
    if (seen !== want) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  // Bounded waits: a stalled link shows up as a mismatch, not a hang
  task automatic xfer(input logic rdn, input logic [2:0] code, input logic [23:0] wd,
                      input logic rs, output logic [23:0] data);
    int n;
    n = 0;
    data = 24'h00_0000;
    while (req_ready !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    req_valid = 1'b1;
    req_read = rdn;
    req_reg = code;
    req_wdata = wd;
    req_resync = rs;
    @(negedge clk);
    req_valid = 1'b0;
    if (rdn) begin
      n = 0;
      while (rsp_valid !== 1'b1 && n < 5000) begin
        @(negedge clk);
        n++;
      end
      data = rsp_data;
    end
    if (n >= 5000) begin
      check(24'h00_0001, 24'h00_0000);
    end
  endtask : xfer

  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    test_done();
  end

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    result_word = 16'h0000;
    result_strobe = 1'b0;
    req_valid = 1'b0;
    req_read = 1'b0;
    req_reg = 3'h0;
    req_wdata = 24'h00_0000;
    req_resync = 1'b0;
    mismatches = 0;
    checked = 0;
    codes = '{`REG_SETUP, `REG_CLOCK, `REG_OFFSET, `REG_GAIN};
    vals = '{24'h00_009C, 24'h00_0005, 24'hA5_C381, 24'h3C_5A96};
    repeat (6) @(negedge clk);
    reset = 1'b0;
    xfer(1'b1, `REG_CLOCK, 24'h00_0000, 1'b0, rd);
    check(rd, {16'h0000, `BOOT_CLOCK});
    check({16'h0000, setup_value}, {16'h0000, `BOOT_SETUP});
    check({23'h00_0000, boot_done}, 24'h00_0001);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, codes[i], vals[i], 1'b0, rd);
      xfer(1'b1, codes[i], 24'h00_0000, 1'b0, rd);
      check(rd, vals[i]);
    end
    check({16'h0000, setup_value}, vals[0]);
    check({16'h0000, clock_value}, vals[1]);
    check(offset_value, vals[2]);
    check(gain_value, vals[3]);
    xfer(1'b0, 3'h4, 24'h00_00FF, 1'b0, rd);
    xfer(1'b1, 3'h4, 24'h00_0000, 1'b0, rd);
    check(rd, 24'h00_0000);
    // Flag high; command bits shown are those stored by the code-4 read before
    xfer(1'b1, `REG_COMM, 24'h00_0000, 1'b0, rd);
    check(rd, 24'h00_00C8);
    result_word = 16'hB38E;
    result_strobe = 1'b1;
    @(negedge clk);
    result_strobe = 1'b0;
    repeat (10) @(negedge clk);
    check({23'h00_0000, bus.result_ready_n}, 24'h00_0000);
    xfer(1'b1, `REG_COMM, 24'h00_0000, 1'b0, rd);
    check(rd, 24'h00_0008);
    xfer(1'b1, `REG_DATA, 24'h00_0000, 1'b0, rd);
    check(rd, 24'h00_B38E);
    repeat (30) @(negedge clk);
    check({23'h00_0000, bus.result_ready_n}, 24'h00_0001);
    xfer(1'b0, `REG_COMM, 24'h00_0000, 1'b1, rd);
    xfer(1'b1, `REG_SETUP, 24'h00_0000, 1'b0, rd);
    check(rd, vals[0]);
    check(offset_value, vals[2]);
    test_done();
  end
endmodule : tb
